// ### design/spc_pkg.sv
// Purpose: Shared constants and types for the standalone phrase playback block.
// Assumes: 50 MHz mclk, 32-bit classic Wishbone register access.
// Notes:   Rate and tone tables are kept in units of 100 Hz.
package spc_pkg;
    localparam int unsigned SPC_CLK_HZ       = 50_000_000;
    localparam int unsigned SPC_DEBOUNCE_MS  = 16;
    localparam int unsigned SPC_FADE_STEP_MS = 64;
    localparam int unsigned SPC_MS_PER_S     = 1000;
    localparam int unsigned SPC_DHZ_HZ       = 100;
    localparam int unsigned SPC_RATE_DHZ [8] = '{40, 53, 64, 80, 106, 128, 160, 320};
    localparam int unsigned SPC_BEEP_DHZ [4] = '{5, 10, 13, 20};
    localparam logic [2:0]  SPC_RATE_TOP     = 3'h7;
    localparam logic [2:0]  SPC_RATE_RC_TOP  = 3'h6;
    localparam logic [6:0]  SPC_BEEP_BASE    = 7'h7c;
    localparam logic [6:0]  SPC_LFSR_SEED    = 7'h5a;
    localparam logic [2:0]  SPC_FADE_LAST    = 3'h4;
    localparam logic [7:0]  SPC_REG_CTRL     = 8'h00;
    localparam logic [7:0]  SPC_REG_LEN      = 8'h04;
    localparam logic [7:0]  SPC_REG_DATA     = 8'h08;
    localparam logic [7:0]  SPC_REG_STAT     = 8'h0c;
    localparam logic [6:0]  SPC_CTRL_RST     = 7'h00;
    localparam logic [15:0] SPC_LEN_RST      = 16'h0100;
    localparam logic [11:0] SPC_STEP_MIN     = 12'h010;
    localparam logic [11:0] SPC_STEP_MAX     = 12'h400;
    localparam logic [11:0] SPC_BEEP_HI      = 12'h3ff;
    localparam logic [11:0] SPC_BEEP_LO      = 12'hc00;
    localparam logic [11:0] SPC_POS_MAX      = 12'h7ff;
    localparam logic [11:0] SPC_NEG_MAX      = 12'h800;
    localparam logic [11:0] SPC_DAC_MID      = 12'h800;

    // Software control word; rnd sits in bit 0 and rate in bits 6:4.
    typedef struct packed {
        logic [2:0] rate;
        logic       fade;
        logic       mix;
        logic       adpcm;
        logic       rnd;
    } spc_ctrl_t;

    // One FIFO word carries one sample byte for each channel.
    typedef struct packed {
        logic [7:0] ch1;
        logic [7:0] ch0;
    } spc_pair_t;

    typedef enum logic [2:0] {
        SPC_ST_IDLE = 3'h1,
        SPC_ST_WAIT = 3'h2,
        SPC_ST_PLAY = 3'h4
    } spc_state_t;
endpackage

// ### design/spc_playback.sv
// Purpose: Standalone phrase trigger, sample decode, mix, fade and DAC feed.
// Assumes: Inputs synchronous to mclk; software streams samples into DATA.
// Notes:   The FIFO depth must be a power of two.
//
// Functional notes
// - Reset holds the device in standby.
// - Reset stops oscillator, grounds audio, clears state.
// - Busy low during playback, high after power-on.
// - Standby drives oscillator drive pin low.
// - RC mode drives RC pin high in standby.
// - Random trigger fall fetches random phrase, plays.
// - Random mode ignores lowest level phrase input.
// - Change input latches phrase 16 ms later.
// - Eight selectable sampling rates supported.
// - No 32 kHz rate under RC oscillation.
// - Four beep tones chosen by specific codes.
// - Decode 4-bit ADPCM or 8-bit PCM.
// - Fade-out through four attenuation steps.
// - Two channels mix into one stream.
// - Samples reach the DAC as 12-bit codes.
`timescale 1ns/1ns
`default_nettype none

module spc_fifo #(
    parameter int unsigned WIDTH = 16,
    parameter int unsigned DEPTH = 8
) (
    input  wire logic             clk,
    input  wire logic             rst,
    input  wire logic             in_valid,
    input  wire logic [WIDTH-1:0] in_data,
    output logic                  in_ready,
    output logic                  out_valid,
    output logic [WIDTH-1:0]      out_data,
    input  wire logic             out_ready
);
    localparam int unsigned AW = $clog2(DEPTH);
    logic [WIDTH-1:0] mem_q [DEPTH];
    logic [AW-1:0]    wr_q;
    logic [AW-1:0]    rd_q;
    logic [AW:0]      cnt_q;
    wire              push = in_valid && in_ready;
    wire              pop  = out_valid && out_ready;

    assign in_ready  = cnt_q != (AW+1)'(DEPTH);
    assign out_valid = cnt_q != '0;
    assign out_data  = mem_q[rd_q];

    always_ff @(posedge clk) begin
        if (push) begin
            mem_q[wr_q] <= in_data;
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            wr_q  <= '0;
            rd_q  <= '0;
            cnt_q <= '0;
        end else begin
            wr_q  <= wr_q + AW'(push);
            rd_q  <= rd_q + AW'(pop);
            cnt_q <= cnt_q + (AW+1)'(push) - (AW+1)'(pop);
        end
    end
endmodule // spc_fifo

module spc_playback import spc_pkg::*; #(
    parameter int unsigned CLK_HZ     = SPC_CLK_HZ,
    parameter int unsigned DEB_CYC    = SPC_DEBOUNCE_MS * (SPC_CLK_HZ / SPC_MS_PER_S),
    parameter int unsigned FADE_CYC   = SPC_FADE_STEP_MS * (SPC_CLK_HZ / SPC_MS_PER_S),
    parameter int unsigned FIFO_DEPTH = 8
) (
    input  wire logic        mclk,
    input  wire logic        reset,
    input  wire logic        oscillator_type_select,
    input  wire logic        random_trigger_n,
    input  wire logic [3:0]  phrase_change_inputs,
    input  wire logic [2:0]  phrase_level_inputs,
    input  wire logic        wb_cyc_i,
    input  wire logic        wb_stb_i,
    input  wire logic        wb_we_i,
    input  wire logic [7:0]  wb_adr_i,
    input  wire logic [3:0]  wb_sel_i,
    input  wire logic [31:0] wb_dat_i,
    output logic             wb_ack_o,
    output logic [31:0]      wb_dat_o,
    output logic             busy_n,
    output logic [11:0]      audio_output,
    output logic             oscillator_drive_pin,
    output logic             rc_network_pin
);
    localparam int unsigned DW = $clog2(DEB_CYC + 1);
    localparam int unsigned FW = $clog2(FADE_CYC + 1);

    spc_state_t         st_q;
    spc_state_t         st_d;
    spc_ctrl_t          ctrl_q;
    logic [15:0]        len_q;
    logic [6:0]         phrase_q;
    logic [6:0]         lfsr_q;
    logic               rnd_prev_q;
    logic [3:0]         sw_prev_q;
    logic [DW-1:0]      deb_q;
    logic [23:0]        rate_cnt_q;
    logic [23:0]        beep_cnt_q;
    logic               beep_q;
    logic [15:0]        smp_cnt_q;
    logic [FW-1:0]      fade_cnt_q;
    logic [2:0]         fade_lvl_q;
    logic signed [11:0] smp_q [2];
    logic [23:0]        rate_div [8];
    logic [23:0]        beep_half [4];
    spc_pair_t          fifo_data;
    logic               fifo_in_ready;
    logic               fifo_valid;

    // Register slave; a DATA write into a full FIFO waits for room.
    wire        wb_req  = wb_cyc_i && wb_stb_i && !wb_ack_o;
    wire        hit_ctl = wb_adr_i == SPC_REG_CTRL;
    wire        hit_len = wb_adr_i == SPC_REG_LEN;
    wire        hit_dat = wb_adr_i == SPC_REG_DATA;
    wire        hit_sta = wb_adr_i == SPC_REG_STAT;
    wire        data_wr = wb_req && wb_we_i && hit_dat;
    wire        wb_go   = wb_req && (!data_wr || fifo_in_ready);
    wire        wr_go   = wb_go && wb_we_i;
    wire [31:0] wmask   = {{8{wb_sel_i[3]}}, {8{wb_sel_i[2]}},
                           {8{wb_sel_i[1]}}, {8{wb_sel_i[0]}}};
    wire [31:0] ctl_old = {25'h000_0000, ctrl_q};
    wire [31:0] len_old = {16'h0000, len_q};
    wire [31:0] ctl_new = (ctl_old & ~wmask) | (wb_dat_i & wmask);
    wire [31:0] len_new = (len_old & ~wmask) | (wb_dat_i & wmask);
    wire        busy    = st_q == SPC_ST_PLAY;
    wire [31:0] stat_w  = {13'h0000, fade_lvl_q, 1'b0, phrase_q, 5'h00,
                           !fifo_in_ready, !fifo_valid, busy};
    wire [31:0] rd_mux  = hit_ctl ? ctl_old :
                          hit_len ? len_old :
                          hit_sta ? stat_w : 32'h0000_0000;

    always_ff @(posedge mclk) begin
        if (reset) begin
            wb_ack_o <= 1'b0;
            wb_dat_o <= 32'h0000_0000;
        end else begin
            wb_ack_o <= wb_go;
            wb_dat_o <= (wb_go && !wb_we_i) ? rd_mux : 32'h0000_0000;
        end
    end

    always_ff @(posedge mclk) begin
        if (reset) begin
            ctrl_q <= spc_ctrl_t'(SPC_CTRL_RST);
            len_q  <= SPC_LEN_RST;
        end else begin
            if (wr_go && hit_ctl) begin
                ctrl_q <= spc_ctrl_t'(ctl_new[6:0]);
            end
            if (wr_go && hit_len) begin
                len_q <= len_new[15:0];
            end
        end
    end

    // Trigger detection and phrase selection.
    wire       rnd_fall   = rnd_prev_q && !random_trigger_n;
    wire       rnd_start  = ctrl_q.rnd && rnd_fall && st_q == SPC_ST_IDLE;
    wire       sw_chg     = phrase_change_inputs != sw_prev_q;
    wire       deb_done   = st_q == SPC_ST_WAIT && deb_q == '0 && !sw_chg;
    wire       lvl0       = phrase_level_inputs[0] && !ctrl_q.rnd;
    wire [6:0] sw_phrase  = {phrase_level_inputs[2:1], lvl0, phrase_change_inputs};
    wire       play_start = !busy && st_d == SPC_ST_PLAY;
    wire       beep_play  = phrase_q >= SPC_BEEP_BASE;

    // Derived rates; the top rate folds to the next one under RC clocking.
    wire [2:0] rate_eff = (!oscillator_type_select && ctrl_q.rate == SPC_RATE_TOP) ?
                          SPC_RATE_RC_TOP : ctrl_q.rate;
    wire       sample_tick = busy && rate_cnt_q == rate_div[rate_eff] - 24'h00_0001;
    wire       beep_flip   = beep_cnt_q == beep_half[phrase_q[1:0]] - 24'h00_0001;
    wire       fade_step   = ctrl_q.fade && fade_cnt_q == FW'(FADE_CYC - 1);
    wire       play_end    = busy && ((sample_tick && smp_cnt_q == len_q - 16'h0001) ||
                                      fade_lvl_q == SPC_FADE_LAST);
    wire       pop_ready   = sample_tick && !beep_play;

    genvar gi;
    generate
        for (gi = 0; gi < 8; gi++) begin : g_rate
            assign rate_div[gi] = 24'(CLK_HZ / (SPC_RATE_DHZ[gi] * SPC_DHZ_HZ));
        end
        for (gi = 0; gi < 4; gi++) begin : g_beep
            assign beep_half[gi] = 24'(CLK_HZ / (2 * SPC_BEEP_DHZ[gi] * SPC_DHZ_HZ));
        end
    endgenerate

    always_comb begin
        st_d = st_q;
        case (st_q)
            SPC_ST_IDLE: begin
                if (rnd_start) begin
                    st_d = SPC_ST_PLAY;
                end else if (sw_chg) begin
                    st_d = SPC_ST_WAIT;
                end
            end
            SPC_ST_WAIT: begin
                if (deb_done) begin
                    st_d = SPC_ST_PLAY;
                end
            end
            SPC_ST_PLAY: begin
                if (play_end) begin
                    st_d = SPC_ST_IDLE;
                end
            end
            default: st_d = SPC_ST_IDLE;
        endcase
    end

    always_ff @(posedge mclk) begin
        if (reset) begin
            st_q       <= SPC_ST_IDLE;
            rnd_prev_q <= 1'b1;
            sw_prev_q  <= 4'h0;
            lfsr_q     <= SPC_LFSR_SEED;
            deb_q      <= '0;
            phrase_q   <= 7'h00;
        end else begin
            st_q       <= st_d;
            rnd_prev_q <= random_trigger_n;
            sw_prev_q  <= phrase_change_inputs;
            lfsr_q     <= {lfsr_q[5:0], lfsr_q[6] ^ lfsr_q[5]};
            if (sw_chg) begin
                deb_q <= DW'(DEB_CYC - 1);
            end else if (deb_q != '0) begin
                deb_q <= deb_q - DW'(1);
            end
            if (rnd_start) begin
                phrase_q <= lfsr_q;
            end else if (deb_done) begin
                phrase_q <= sw_phrase;
            end
        end
    end

    // Pacing counters run only while playing, so standby burns no toggles.
    always_ff @(posedge mclk) begin
        if (reset || !busy) begin
            rate_cnt_q <= 24'h00_0000;
            beep_cnt_q <= 24'h00_0000;
            beep_q     <= 1'b0;
            smp_cnt_q  <= 16'h0000;
            fade_cnt_q <= '0;
            fade_lvl_q <= 3'h0;
        end else begin
            rate_cnt_q <= sample_tick ? 24'h00_0000 : rate_cnt_q + 24'h00_0001;
            beep_cnt_q <= beep_flip ? 24'h00_0000 : beep_cnt_q + 24'h00_0001;
            beep_q     <= beep_q ^ beep_flip;
            smp_cnt_q  <= smp_cnt_q + 16'(sample_tick);
            if (ctrl_q.fade) begin
                fade_cnt_q <= fade_step ? '0 : fade_cnt_q + FW'(1);
            end
            if (fade_step && fade_lvl_q != SPC_FADE_LAST) begin
                fade_lvl_q <= fade_lvl_q + 3'h1;
            end
        end
    end

    spc_fifo #(
        .WIDTH ($bits(spc_pair_t)),
        .DEPTH (FIFO_DEPTH)
    ) u_fifo (
        .clk       (mclk),
        .rst       (reset),
        .in_valid  (data_wr),
        .in_data   (wb_dat_i[$bits(spc_pair_t)-1:0]),
        .in_ready  (fifo_in_ready),
        .out_valid (fifo_valid),
        .out_data  (fifo_data),
        .out_ready (pop_ready)
    );

    wire pop = pop_ready && fifo_valid;

    // Per-channel decoder; an empty FIFO at a tick repeats the last sample.
    generate
        for (gi = 0; gi < 2; gi++) begin : g_ch
            logic [11:0]        step_q;
            logic signed [11:0] pred_q;
            wire [7:0]          byte_w = fifo_data[gi*8 +: 8];
            wire [14:0]         prod   = 15'(step_q) * 15'(byte_w[2:0]);
            wire signed [13:0]  pext   = {{2{pred_q[11]}}, pred_q};
            wire signed [13:0]  dext   = {1'b0, prod[14:2]};
            wire signed [13:0]  sum    = byte_w[3] ? pext - dext : pext + dext;
            wire                ovf    = sum[13:11] != {3{sum[13]}};
            wire [11:0]         sat    = ovf ? (sum[13] ? SPC_NEG_MAX : SPC_POS_MAX) :
                                         sum[11:0];
            wire [11:0]         up     = (step_q >= SPC_STEP_MAX) ? SPC_STEP_MAX :
                                         {step_q[10:0], 1'b0};
            wire [11:0]         dn     = (step_q <= SPC_STEP_MIN) ? SPC_STEP_MIN :
                                         {1'b0, step_q[11:1]};
            wire [11:0]         pcm    = {byte_w, 4'h0};

            always_ff @(posedge mclk) begin
                if (reset || play_start) begin
                    step_q    <= SPC_STEP_MIN;
                    pred_q    <= 12'sh000;
                    smp_q[gi] <= 12'sh000;
                end else if (pop) begin
                    if (ctrl_q.adpcm) begin
                        step_q    <= byte_w[2] ? up : dn;
                        pred_q    <= signed'(sat);
                        smp_q[gi] <= signed'(sat);
                    end else begin
                        smp_q[gi] <= signed'(pcm);
                    end
                end
            end
        end
    endgenerate

    // Mix, attenuate and convert to offset binary for the converter.
    wire signed [11:0] beep_w = signed'(beep_q ? SPC_BEEP_HI : SPC_BEEP_LO);
    wire signed [11:0] ch0_w  = beep_play ? beep_w : smp_q[0];
    wire signed [11:0] ch1_w  = ctrl_q.mix && !beep_play ? smp_q[1] : 12'sh000;
    wire signed [12:0] mix_w  = 13'(ch0_w) + 13'(ch1_w);
    wire               mov    = mix_w[12] != mix_w[11];
    wire signed [11:0] msat   = mov ? signed'(mix_w[12] ? SPC_NEG_MAX : SPC_POS_MAX) :
                                mix_w[11:0];
    wire signed [11:0] faded  = msat >>> fade_lvl_q;
    wire [11:0]        dac_w  = faded ^ SPC_DAC_MID;
    wire               stby   = st_d != SPC_ST_PLAY;
    // A new phrase opens at mid-scale so the old phrase's last sample never leaks out.
    wire [11:0]        aud_w  = stby ? 12'h000 : (play_start ? SPC_DAC_MID : dac_w);

    always_ff @(posedge mclk) begin
        if (reset) begin
            busy_n               <= 1'b1;
            audio_output         <= 12'h000;
            oscillator_drive_pin <= 1'b0;
            rc_network_pin       <= 1'b1;
        end else begin
            busy_n               <= stby;
            audio_output         <= aud_w;
            oscillator_drive_pin <= stby ? 1'b0 : !oscillator_drive_pin;
            rc_network_pin       <= stby ? !oscillator_type_select :
                                    !oscillator_type_select && oscillator_drive_pin;
        end
    end

    reset_state_a: assert property (@(posedge mclk) reset |=>
        (audio_output == 12'h000 && busy_n && !oscillator_drive_pin && st_q == SPC_ST_IDLE))
        else $error("Reset did not force standby outputs.");
    busy_tracks_a: assert property (@(posedge mclk) disable iff (reset)
        busy_n == (st_q != SPC_ST_PLAY))
        else $error("Busy output disagrees with playback state.");
    osc_standby_a: assert property (@(posedge mclk) disable iff (reset)
        (st_q != SPC_ST_PLAY) |-> !oscillator_drive_pin)
        else $error("Oscillator drive pin not low in standby.");
    rc_standby_a: assert property (@(posedge mclk) disable iff (reset)
        (st_q != SPC_ST_PLAY && !$past(oscillator_type_select)) |-> rc_network_pin)
        else $error("RC pin not high in standby.");
    random_start_a: assert property (@(posedge mclk) disable iff (reset)
        rnd_start |=> (st_q == SPC_ST_PLAY && phrase_q == $past(lfsr_q)))
        else $error("Random trigger did not start random phrase.");
    level_mask_a: assert property (@(posedge mclk) disable iff (reset)
        (deb_done && ctrl_q.rnd) |=> !phrase_q[4])
        else $error("Lowest level input not ignored in random mode.");
    debounce_wait_a: assert property (@(posedge mclk) disable iff (reset)
        (st_q == SPC_ST_WAIT && (deb_q != '0 || sw_chg)) |=> st_q != SPC_ST_PLAY)
        else $error("Phrase latched before settle time.");
    rc_rate_a: assert property (@(posedge mclk) disable iff (reset)
        !oscillator_type_select |-> rate_eff != SPC_RATE_TOP)
        else $error("Top rate used under RC clocking.");
    fade_bound_a: assert property (@(posedge mclk) disable iff (reset)
        (busy && fade_lvl_q == SPC_FADE_LAST) |=> st_q == SPC_ST_IDLE && busy_n)
        else $error("Playback not ended after last fade step.");
    idle_silent_a: assert property (@(posedge mclk) disable iff (reset)
        (busy && play_end) |=> (busy_n && audio_output == 12'h000))
        else $error("Output not quiet after playback end.");
endmodule // spc_playback

`default_nettype wire

// ### test/spc_switch_model.sv
// Purpose: Push switch and port pin model for the phrase inputs.
// Assumes: Every change lands just after a rising mclk edge.
// Notes:   Idle levels follow the pin pulls: trigger high, change inputs low.
`timescale 1ns/1ns
`default_nettype none
module spc_switch_model (
    input  wire logic  mclk,
    output logic       oscillator_type_select,
    output logic       random_trigger_n,
    output logic [3:0] phrase_change_inputs,
    output logic [2:0] phrase_level_inputs
);
    initial begin
        oscillator_type_select = 1'b1;
        random_trigger_n       = 1'b1;
        phrase_change_inputs   = 4'h0;
        phrase_level_inputs    = 3'h0;
    end
    // Level bits settle a cycle before the change that starts the phrase.
    task automatic press(input logic [2:0] lv, input logic [3:0] cg);
        @(posedge mclk);
        phrase_level_inputs <= lv;
        @(posedge mclk);
        phrase_change_inputs <= cg;
    endtask
    task automatic kick();
        @(posedge mclk);
        random_trigger_n <= 1'b0;
        repeat (3) @(posedge mclk);
        random_trigger_n <= 1'b1;
    endtask
    task automatic set_osc(input logic xt);
        @(posedge mclk);
        oscillator_type_select <= xt;
    endtask
endmodule // spc_switch_model
`default_nettype wire

// ### test/standalone_phrase_playback_control_tb.sv
// Purpose: Self-checking bench for the standalone phrase playback block.
// Assumes: Shortened clock, settle and fade counts keep the run brief.
// Notes:   Audio results are noted in a queue and checked by a monitor.
`timescale 1ns/1ns
`default_nettype none
module standalone_phrase_playback_control_tb import spc_pkg::*;;
    localparam int unsigned HZ  = 400000;
    localparam int unsigned DEB = 20;
    localparam int unsigned FAD = 50;
    localparam logic [7:0]  RA[5] = '{8'h10, SPC_REG_CTRL, SPC_REG_LEN, SPC_REG_DATA, SPC_REG_STAT};
    localparam logic [31:0] RV[5] = '{32'h0, 32'h0, 32'h0000_0100, 32'h0, 32'h0000_0002};
    logic        mclk, reset, xt, rnd_n, cyc, stb, we, ack, busy_n, osc, rcp, ob;
    logic [3:0]  chg, sel;
    logic [2:0]  lvl;
    logic [7:0]  adr;
    logic [31:0] wdat, rdat, q;
    logic [11:0] audio, last_a;
    logic [11:0] notes[$];
    int          n_fail, num_checks, gap, last_t, k, sd;
    int          cyc_n = 0;
    bit          watch;

    spc_switch_model u_spc_switch_model (.mclk(mclk), .oscillator_type_select(xt),
        .random_trigger_n(rnd_n), .phrase_change_inputs(chg), .phrase_level_inputs(lvl));
    spc_playback #(.CLK_HZ(HZ), .DEB_CYC(DEB), .FADE_CYC(FAD), .FIFO_DEPTH(8)) u_spc_playback (
        .mclk(mclk), .reset(reset), .oscillator_type_select(xt), .random_trigger_n(rnd_n),
        .phrase_change_inputs(chg), .phrase_level_inputs(lvl), .wb_cyc_i(cyc), .wb_stb_i(stb),
        .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat), .wb_ack_o(ack),
        .wb_dat_o(rdat), .busy_n(busy_n), .audio_output(audio), .oscillator_drive_pin(osc),
        .rc_network_pin(rcp));

    initial begin
        mclk = 1'b0;
        forever #10 mclk = ~mclk;
    end

    task automatic report_and_stop();
        $display("checks %0d mismatches %0d", num_checks, n_fail);
        if (n_fail == 0 && num_checks > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask

    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        num_checks++;
        if (e !== g) begin
            n_fail++;
            $display("unexpected %s: expected %h seen %h", nm, e, g);
        end
    endtask

    always @(posedge mclk) begin
        cyc_n <= cyc_n + 1;
        if (cyc_n == 40000) begin
            n_fail++;
            report_and_stop();
        end
    end

    // Only changes are seen, so notes are built so that neighbours differ.
    always @(negedge mclk) begin
        if (busy_n === 1'b0 && audio !== last_a && audio !== SPC_DAC_MID) begin
            gap = cyc_n - last_t;
            last_t = cyc_n;
            if (watch) chk("audio", notes.size() ? notes.pop_front() : ~audio, audio);
        end
        last_a = audio;
    end

    task automatic bus(input logic [7:0] a, input logic w, input logic [31:0] d);
        @(posedge mclk);
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        adr <= a;
        wdat <= d;
        do begin
            @(posedge mclk);
        end while (ack !== 1'b1);
        q = rdat;
        cyc <= 1'b0;
        stb <= 1'b0;
        if (w) chk("write data", 32'h0, rdat);
    endtask

    task automatic wait_busy(input logic v, output int n);
        n = 0;
        while (busy_n !== v && n < 5000) begin
            @(negedge mclk);
            n++;
        end
        if (n >= 5000) chk("busy wait", 1, 0);
    endtask

    task automatic standby();
        @(negedge mclk);
        chk("standby", 32'h4001, {17'h0, busy_n, audio, osc, rcp});
    endtask

    function automatic logic [11:0] pcm(input logic [7:0] b0, input logic [7:0] b1, input logic mx);
        logic signed [12:0] s;
        s = $signed({b0[7], b0, 4'h0}) + (mx ? $signed({b1[7], b1, 4'h0}) : 13'sd0);
        if (s > 13'sd2047) s = 13'sd2047;
        if (s < -13'sd2048) s = -13'sd2048;
        return {~s[11], s[10:0]};
    endfunction

    // One extra tick in the length makes sure the last pair is popped before the end.
    task automatic play(input logic [6:0] ctl, input logic [2:0] lv, input logic [3:0] cg,
                        input int n, input int div);
        logic [7:0]  b0, b1;
        logic [11:0] e, pe;
        int          st, pr, p;
        pe = 12'h000;
        st = SPC_STEP_MIN;
        pr = 0;
        bus(SPC_REG_LEN, 1'b1, 32'(n + 1));
        bus(SPC_REG_CTRL, 1'b1, {25'h0, ctl});
        for (int i = 0; i < n; i++) begin
            do begin
                b0 = 8'($urandom);
                b1 = 8'($urandom);
                p = st * b0[2:0] / 4;
                p = b0[3] ? pr - p : pr + p;
                p = p > 2047 ? 2047 : (p < -2048 ? -2048 : p);
                e = ctl[1] ? 12'(p) ^ SPC_DAC_MID : pcm(b0, b1, ctl[2]);
            end while (e == pe || e == 12'h000 || e == SPC_DAC_MID);
            pe = e;
            pr = p;
            st = b0[2] ? (st < SPC_STEP_MAX ? 2 * st : st) : (st > SPC_STEP_MIN ? st / 2 : st);
            notes.push_back(e);
            bus(SPC_REG_DATA, 1'b1, {16'h0, b1, b0});
        end
        bus(SPC_REG_STAT, 1'b0, 32'h0);
        chk("fifo", n == 8 ? 32'h4 : 32'h0, q & 32'h6);
        u_spc_switch_model.press(lv, cg);
        wait_busy(1'b0, k);
        chk("settle", 1, 32'(k >= DEB && k <= DEB + 4));
        ob = osc;
        @(negedge mclk);
        chk("osc", {31'h0, ~ob}, {31'h0, osc});
        bus(SPC_REG_STAT, 1'b0, 32'h0);
        chk("phrase", {25'h0, lv[2:1], lv[0] & ~ctl[0], cg}, {25'h0, q[14:8]});
        wait_busy(1'b1, k);
        chk("idle", 32'he, {28'h0, busy_n, 1'(audio === 12'h0), 1'(notes.size() == 0), osc});
        chk("tick", 1, 32'(gap >= div - 1 && gap <= div + 1));
    endtask

    initial begin
        reset = 1'b1;
        {cyc, stb, we, adr, wdat} = '0;
        sel = 4'hf;
        watch = 1'b1;
        last_a = 12'h0;
        {n_fail, num_checks, last_t} = '0;
        sd = $urandom(32'h169b);
        repeat (5) @(posedge mclk);
        standby();
        @(posedge mclk);
        reset <= 1'b0;
        bus(8'h10, 1'b1, 32'hffff_ffff);
        for (int i = 0; i < 5; i++) begin
            bus(RA[i], 1'b0, 32'h0);
            chk("register", RV[i], q);
        end
        for (int r = 0; r < 8; r++) begin
            play({3'(r), 4'h0}, 3'h1, 4'(r + 1), r == 0 ? 8 : 3, HZ / (SPC_RATE_DHZ[r] * 100));
        end
        u_spc_switch_model.set_osc(1'b0);
        play(7'h70, 3'h1, 4'h9, 3, HZ / (SPC_RATE_DHZ[6] * 100));
        u_spc_switch_model.set_osc(1'b1);
        play(7'h04, 3'h3, 4'ha, 4, 100);
        play(7'h01, 3'h1, 4'hb, 2, 100);
        play(7'h02, 3'h1, 4'h3, 4, 100);
        watch = 1'b0;
        bus(SPC_REG_LEN, 1'b1, 32'h0000_ffff);
        bus(SPC_REG_CTRL, 1'b1, 32'h0000_0008);
        u_spc_switch_model.press(3'h0, 4'h5);
        wait_busy(1'b0, k);
        wait_busy(1'b1, k);
        chk("fade", 1, 32'(k >= 3 * FAD && k <= 4 * FAD + 8));
        bus(SPC_REG_LEN, 1'b1, 32'h0000_0014);
        bus(SPC_REG_CTRL, 1'b1, 32'h0);
        for (int t = 0; t < 4; t++) begin
            u_spc_switch_model.press(3'h7, 4'hc + 4'(t));
            wait_busy(1'b0, k);
            wait_busy(1'b1, k);
            k = HZ / (2 * SPC_BEEP_DHZ[t] * 100);
            chk("beep", 1, 32'(gap >= k - 2 && gap <= k + 2));
        end
        bus(SPC_REG_CTRL, 1'b1, 32'h1);
        u_spc_switch_model.kick();
        @(negedge mclk);
        chk("random", 0, {31'h0, busy_n});
        @(posedge mclk);
        reset <= 1'b1;
        repeat (2) @(posedge mclk);
        standby();
        @(posedge mclk);
        reset <= 1'b0;
        u_spc_switch_model.set_osc(1'b0);
        repeat (2) @(posedge mclk);
        @(negedge mclk);
        chk("rc pin", 32'h1, {31'h0, rcp});
        bus(SPC_REG_CTRL, 1'b0, 32'h0);
        chk("ctrl", 32'h0, q);
        report_and_stop();
    end
endmodule // standalone_phrase_playback_control_tb
`default_nettype wire
